// file: verilog/dsl_top.sv
// Deep sleep control and peripheral module-disable write protection.
// Assumes a single-cycle register port and synchronous event inputs.
//
// Functional notes
// - Control register bits 7..3 always read zero; writes there do nothing.
// - Wake disable set means external wake is ignored in deep sleep.
// - Brown-out flag sets only when enabled and supply drops during deep sleep.
// - A deep sleep brown-out never wakes the device; it is only recorded.
// - Release bit set after deep wake holds pins; clearing hands them back.
// - Locked module-disable writes complete normally but change nothing.
// - Lock bit 12 blocks module-disable writes when set, allows when clear.
// - Changing the lock bit needs the unlock key sequence first.
// - One-way fuse bit 28 stops a set lock from being cleared.
// - A fused lock is cleared only by device reset.
// - Wait with deep sleep enable enters deep sleep, otherwise plain sleep.
//
// The placing of the registers and the strobed register port were chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none
module dsl_top
    import dsl_pkg::*;
#(
    parameter int NPMD = 4,
    parameter int NPIN = 16
)
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Register port
    input wire logic [7:0] addr,
    input wire logic [31:0] wdata,
    input wire logic wr_en,
    input wire logic rd_en,
    output logic [31:0] rdata,
    // Configuration words, sampled once after reset
    input wire logic [31:0] config_word3,
    input wire logic deep_sleep_enable_fuse,
    input wire logic brownout_enable_fuse,
    // Power events
    input wire logic wait_exec,
    input wire logic wake_ext,
    input wire logic wake_other,
    input wire logic supply_low,
    // Power state
    output logic in_sleep,
    output logic in_deep_sleep,
    output logic pins_held,
    // Pins
    input wire logic [NPIN-1:0] pin_direction,
    input wire logic [NPIN-1:0] pin_output_latch,
    output logic [NPIN-1:0] pin_dir_out,
    output logic [NPIN-1:0] pin_lat_out,
    // Module disable
    output logic [NPMD*32-1:0] module_disable,
    output logic disable_locked
);
    localparam int IW = (NPMD > 1) ? $clog2(NPMD) : 1;
    localparam int MD_SPAN = NPMD * 4;

    typedef struct packed {
        pwr_state_t st;
        logic sleep_o;
        logic deep_o;
        logic hold_o;
        logic deep_sleep_enable;
        logic external_wake_disable;
        logic deep_sleep_brownout_flag;
        logic release_pins;
        logic woke_deep;
        logic straps_done;
        logic one_way;
        logic deep_sleep_brownout_enable;
        logic [NPMD-1:0][31:0] mdis;
        logic [31:0] rdata;
    } top_st_t;

    top_st_t s_r;
    top_st_t s_nxt;
    logic [IW-1:0] wr_idx;
    logic [IW-1:0] rd_idx;
    logic deep_wake;

    dsl_sub_if #(.NPIN(NPIN)) sub ();

    // Address decode for the module-disable block, used by read and write
    function automatic logic md_hit(input logic [7:0] a);
        logic [7:0] rel;
        rel = a - MD_BASE;
        return (a >= MD_BASE) && (int'(rel) < MD_SPAN) &&
            (a[1:0] == 2'b00);
    endfunction

    function automatic logic [IW-1:0] md_index(input logic [7:0] a);
        logic [7:0] rel;
        rel = a - MD_BASE;
        return rel[IW+1:2];
    endfunction

    // Read image of the deep sleep control register
    function automatic logic [31:0] dsctl_word(input top_st_t s);
        logic [31:0] w;
        w = 32'h0000_0000;
        w[DS_ENABLE_BIT] = s.deep_sleep_enable;
        w[WAKE_OFF_BIT] = s.external_wake_disable;
        w[BOR_FLAG_BIT] = s.deep_sleep_brownout_flag;
        w[RELEASE_BIT] = s.release_pins;
        return w;
    endfunction

    assign wr_idx = md_index(addr);
    assign rd_idx = md_index(addr);

    // Requests to the lock helper
    assign sub.key_wr = wr_en && (addr == KEY_OFS);
    assign sub.cfg_wr = wr_en && (addr == CFGCTL_OFS);
    assign sub.wdata = wdata;
    assign sub.one_way = s_r.one_way;

    // Pin hold follows the registered hold state
    assign sub.hold = s_r.hold_o;
    assign sub.dir_in = pin_direction;
    assign sub.lat_in = pin_output_latch;

    dsl_lock u_lock (
        .clk(clk),
        .rst(rst),
        .lk(sub.lk)
    );

    dsl_pin_hold #(.NPIN(NPIN)) u_hold (
        .clk(clk),
        .rst(rst),
        .ph(sub.ph)
    );

    // External wake counts only when not disabled; other sources always
    assign deep_wake = wake_other ||
        (wake_ext && !s_r.external_wake_disable);

    // Next-state logic for power control, registers and read data
    always_comb begin
        s_nxt = s_r;

        // Straps are caught on the first clean cycle after reset
        if (!s_r.straps_done) begin
            s_nxt.straps_done = 1'b1;
            s_nxt.one_way = config_word3[ONE_WAY_BIT];
            s_nxt.deep_sleep_brownout_enable = brownout_enable_fuse;
            s_nxt.deep_sleep_enable = deep_sleep_enable_fuse;
        end

        // Software writes to the deep sleep control register
        if (wr_en && addr == DSCTL_OFS) begin
            s_nxt.deep_sleep_enable = wdata[DS_ENABLE_BIT];
            s_nxt.external_wake_disable = wdata[WAKE_OFF_BIT];
            s_nxt.release_pins = wdata[RELEASE_BIT];
            // Flag cannot be faked by software, only cleared
            if (!wdata[BOR_FLAG_BIT]) begin
                s_nxt.deep_sleep_brownout_flag = 1'b0;
            end
            if (!wdata[RELEASE_BIT]) begin
                s_nxt.woke_deep = 1'b0;
            end
        end

        // Module-disable writes are silently dropped while locked
        if (wr_en && md_hit(addr) && !sub.lock) begin
            s_nxt.mdis[wr_idx] = wdata;
        end

        // Power state machine
        unique case (s_r.st)
            PWR_RUN: begin
                if (wait_exec) begin
                    // Enable must already be set when the wait arrives
                    if (s_r.deep_sleep_enable) begin
                        s_nxt.st = PWR_DEEP;
                    end else begin
                        s_nxt.st = PWR_SLEEP;
                    end
                end
            end
            PWR_SLEEP: begin
                if (wake_ext || wake_other) begin
                    s_nxt.st = PWR_RUN;
                end
            end
            PWR_DEEP: begin
                // Brown-out is recorded but is not a wake source
                if (s_r.deep_sleep_brownout_enable && supply_low) begin
                    s_nxt.deep_sleep_brownout_flag = 1'b1;
                end
                if (deep_wake) begin
                    s_nxt.st = PWR_RUN;
                    s_nxt.deep_sleep_enable = 1'b0;
                    s_nxt.woke_deep = 1'b1;
                end
            end
        endcase

        // Pins frozen through deep sleep and after wake while release set
        s_nxt.hold_o = (s_nxt.st == PWR_DEEP) ||
            (s_nxt.woke_deep && s_nxt.release_pins);
        s_nxt.sleep_o = (s_nxt.st == PWR_SLEEP);
        s_nxt.deep_o = (s_nxt.st == PWR_DEEP);

        // Read data stands only in the cycle after the strobe
        s_nxt.rdata = 32'h0000_0000;
        if (rd_en) begin
            if (addr == DSCTL_OFS) begin
                s_nxt.rdata = dsctl_word(s_r);
            end else if (addr == CFGCTL_OFS) begin
                s_nxt.rdata[LOCK_BIT] = sub.lock;
            end else if (md_hit(addr)) begin
                s_nxt.rdata = s_r.mdis[rd_idx];
            end
        end
    end

    // State register
    always_ff @(posedge clk) begin
        if (rst) begin
            s_r <= '{
                st: PWR_RUN,
                deep_sleep_enable: DSCTL_BIT_RST,
                external_wake_disable: DSCTL_BIT_RST,
                deep_sleep_brownout_flag: DSCTL_BIT_RST,
                release_pins: DSCTL_BIT_RST,
                mdis: {NPMD{MD_RST}},
                rdata: 32'h0000_0000,
                default: 1'b0
            };
        end else begin
            s_r <= s_nxt;
        end
    end

    // Outputs straight from flops
    assign rdata = s_r.rdata;
    assign in_sleep = s_r.sleep_o;
    assign in_deep_sleep = s_r.deep_o;
    assign pins_held = s_r.hold_o;
    assign pin_dir_out = sub.dir_out;
    assign pin_lat_out = sub.lat_out;
    assign module_disable = s_r.mdis;
    assign disable_locked = sub.lock;
endmodule
`default_nettype wire

// file: verilog/dsl_pkg.sv
// Shared constants for the deep sleep and module lock block.
// Assumes byte addressing on a plain register port with 32-bit data.
package dsl_pkg;
    // Register offsets (byte addresses)
    localparam logic [7:0] DSCTL_OFS = 8'h00;
    localparam logic [7:0] CFGCTL_OFS = 8'h04;
    localparam logic [7:0] KEY_OFS = 8'h08;
    localparam logic [7:0] MD_BASE = 8'h10;
    // Field positions
    localparam int DS_ENABLE_BIT = 15;
    localparam int WAKE_OFF_BIT = 2;
    localparam int BOR_FLAG_BIT = 1;
    localparam int RELEASE_BIT = 0;
    localparam int LOCK_BIT = 12;
    localparam int ONE_WAY_BIT = 28;
    // Reset values
    localparam logic DSCTL_BIT_RST = 1'b0;
    localparam logic LOCK_RST = 1'b0;
    localparam logic [31:0] MD_RST = 32'h0000_0000;
    // Unlock sequence keys; values are arbitrary
    localparam logic [31:0] UNLOCK_KEY1 = 32'h5a5a_0c01;
    localparam logic [31:0] UNLOCK_KEY2 = 32'ha5a5_0c02;
    // Power states
    typedef enum logic [1:0] {PWR_RUN, PWR_SLEEP, PWR_DEEP} pwr_state_t;
endpackage

// file: verilog/dsl_sub_if.sv
// Carrier between the top level and its lock and pin-hold helpers.
// Assumes the top drives the request side and the helpers answer.
`timescale 1ns/10ps
`default_nettype none
interface dsl_sub_if #(parameter int NPIN = 16);
    // Unlock and lock control
    logic key_wr;
    logic cfg_wr;
    logic [31:0] wdata;
    logic one_way;
    logic lock;
    logic unlocked;
    // Pin hold
    logic hold;
    logic [NPIN-1:0] dir_in;
    logic [NPIN-1:0] lat_in;
    logic [NPIN-1:0] dir_out;
    logic [NPIN-1:0] lat_out;
    modport lk (input key_wr, cfg_wr, wdata, one_way,
        output lock, unlocked);
    modport ph (input hold, dir_in, lat_in, output dir_out, lat_out);
endinterface
`default_nettype wire

// file: verilog/dsl_lock.sv
// Unlock sequence and module-disable lock bit with one-way fuse.
// Assumes key and config writes arrive as one-cycle strobes.
`timescale 1ns/10ps
`default_nettype none
module dsl_lock
    import dsl_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Requests and state
    dsl_sub_if.lk lk
);
    typedef struct packed {
        logic lock;
        logic unlocked;
        logic key1_seen;
    } lk_st_t;

    lk_st_t s_r;
    lk_st_t s_nxt;
    logic new_lock;

    // Key sequencing and guarded lock update
    always_comb begin
        s_nxt = s_r;
        new_lock = lk.wdata[LOCK_BIT];
        if (lk.key_wr) begin
            // Any stray key write drops the unlock, so keys must pair
            s_nxt.unlocked = 1'b0;
            s_nxt.key1_seen = 1'b0;
            if (lk.wdata == UNLOCK_KEY1) begin
                s_nxt.key1_seen = 1'b1;
            end else if (s_r.key1_seen && lk.wdata == UNLOCK_KEY2) begin
                s_nxt.unlocked = 1'b1;
            end
        end
        if (lk.cfg_wr && s_r.unlocked) begin
            // Fuse keeps a set lock until reset
            if (!(lk.one_way && s_r.lock && !new_lock)) begin
                s_nxt.lock = new_lock;
            end
        end
    end

    // State register; only reset clears a fused lock
    always_ff @(posedge clk) begin
        if (rst) begin
            s_r <= '{lock: LOCK_RST, default: 1'b0};
        end else begin
            s_r <= s_nxt;
        end
    end

    assign lk.lock = s_r.lock;
    assign lk.unlocked = s_r.unlocked;
endmodule
`default_nettype wire

// file: verilog/dsl_pin_hold.sv
// Holds pin direction and latch values while hold is asserted.
// Assumes hold rises no later than the cycle the pins must freeze.
`timescale 1ns/10ps
`default_nettype none
module dsl_pin_hold
    import dsl_pkg::*;
#(
    parameter int NPIN = 16
)
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Pin values
    dsl_sub_if.ph ph
);
    typedef struct packed {
        logic [NPIN-1:0] dir;
        logic [NPIN-1:0] lat;
    } ph_st_t;

    ph_st_t s_r;
    ph_st_t s_nxt;

    // Follow port control unless held
    always_comb begin
        s_nxt = s_r;
        if (!ph.hold) begin
            s_nxt.dir = ph.dir_in;
            s_nxt.lat = ph.lat_in;
        end
    end

    // Pins come up as inputs with latches low
    always_ff @(posedge clk) begin
        if (rst) begin
            s_r <= '{dir: '1, lat: '0};
        end else begin
            s_r <= s_nxt;
        end
    end

    assign ph.dir_out = s_r.dir;
    assign ph.lat_out = s_r.lat;
endmodule
`default_nettype wire

// file: test/dsl_top_props.sv
// Checker for the deep sleep and module lock top level.
// Assumes one clock domain and sees only the top-level ports.
`timescale 1ns/10ps
`default_nettype none
module dsl_top_props
    import dsl_pkg::*;
#(
    parameter int NPMD = 4,
    parameter int NPIN = 16
)
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Register port
    input wire logic [7:0] addr,
    input wire logic [31:0] wdata,
    input wire logic wr_en,
    input wire logic rd_en,
    input wire logic [31:0] rdata,
    // Straps and events
    input wire logic [31:0] config_word3,
    input wire logic wait_exec,
    input wire logic wake_ext,
    input wire logic wake_other,
    input wire logic supply_low,
    // Design outputs
    input wire logic in_sleep,
    input wire logic in_deep_sleep,
    input wire logic pins_held,
    input wire logic [NPIN-1:0] pin_dir_out,
    input wire logic [NPIN-1:0] pin_lat_out,
    input wire logic [NPMD*32-1:0] module_disable,
    input wire logic disable_locked
);
    // Shadow of unlock state and wake disable, rebuilt from bus traffic
    typedef struct packed {
        logic k1;
        logic unl;
        logic wd;
    } shadow_t;
    shadow_t sh_r;
    shadow_t sh_nxt;
    logic cfg_wr;
    logic md_wr;
    assign cfg_wr = wr_en && addr == CFGCTL_OFS;
    assign md_wr = wr_en && addr == MD_BASE;
    // Any key write restarts the sequence, so unlock lasts until the next key write
    always_comb begin
        sh_nxt = sh_r;
        if (wr_en && addr == KEY_OFS) begin
            sh_nxt.k1 = wdata == UNLOCK_KEY1;
            sh_nxt.unl = sh_r.k1 && wdata == UNLOCK_KEY2;
        end
        if (wr_en && addr == DSCTL_OFS) begin
            sh_nxt.wd = wdata[WAKE_OFF_BIT];
        end
    end
    // Shadow register
    always_ff @(posedge clk) begin
        if (rst) begin
            sh_r <= '0;
        end else begin
            sh_r <= sh_nxt;
        end
    end
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    chk_ctl_unused_zero: assert property (
        $past(rd_en) && $past(addr) == DSCTL_OFS |-> rdata[7:3] == 5'h0)
        else $error("unused control bits read nonzero");
    chk_wake_ignored: assert property (
        in_deep_sleep && sh_r.wd && wake_ext && !wake_other |=> in_deep_sleep)
        else $error("disabled external wake left deep sleep");
    chk_wake_taken: assert property (
        in_deep_sleep && !sh_r.wd && wake_ext |=> !in_deep_sleep)
        else $error("enabled external wake ignored");
    chk_brownout_no_wake: assert property (
        in_deep_sleep && supply_low && !wake_ext && !wake_other
        |=> in_deep_sleep)
        else $error("brown-out woke the device");
    chk_deep_holds_pins: assert property (
        in_deep_sleep |-> pins_held)
        else $error("pins not held in deep sleep");
    chk_pins_frozen: assert property (
        pins_held && $past(pins_held)
        |-> $stable(pin_dir_out) && $stable(pin_lat_out))
        else $error("held pins changed");
    chk_wait_enters: assert property (
        !in_sleep && !in_deep_sleep && wait_exec |=> in_sleep != in_deep_sleep)
        else $error("wait did not enter exactly one sleep state");
    chk_locked_md_kept: assert property (
        disable_locked && md_wr |=> $stable(module_disable[31:0]))
        else $error("locked module-disable write took effect");
    chk_open_md_write: assert property (
        !disable_locked && md_wr |=> module_disable[31:0] == $past(wdata))
        else $error("unlocked module-disable write lost");
    chk_lock_needs_key: assert property (
        !(cfg_wr && sh_r.unl) |=> $stable(disable_locked))
        else $error("lock changed without unlock");
    chk_one_way_hold: assert property (
        disable_locked && config_word3[ONE_WAY_BIT] |=> disable_locked)
        else $error("fused lock was cleared");
    cover property (in_deep_sleep ##1 !in_deep_sleep);
    cover property (in_sleep);
    cover property (disable_locked && config_word3[ONE_WAY_BIT]);
endmodule
bind dsl_top dsl_top_props #(.NPMD(NPMD), .NPIN(NPIN)) u_props (
    .clk(clk), .rst(rst), .addr(addr), .wdata(wdata), .wr_en(wr_en),
    .rd_en(rd_en), .rdata(rdata), .config_word3(config_word3),
    .wait_exec(wait_exec), .wake_ext(wake_ext), .wake_other(wake_other),
    .supply_low(supply_low), .in_sleep(in_sleep),
    .in_deep_sleep(in_deep_sleep), .pins_held(pins_held),
    .pin_dir_out(pin_dir_out), .pin_lat_out(pin_lat_out),
    .module_disable(module_disable), .disable_locked(disable_locked)
);
`default_nettype wire

// file: test/deep_sleep_and_module_lock_test.sv
// Self-checking bench for the deep sleep and module lock top level.
// Assumes the checker is bound in; this module drives every input.
`timescale 1ns/10ps
`default_nettype none
module deep_sleep_and_module_lock_test
    import dsl_pkg::*;
;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [7:0] addr = 8'h0;
    logic [31:0] wdata = 32'h0;
    logic [31:0] cw3 = 32'h0;
    logic [31:0] rdata;
    logic [31:0] val;
    logic wr_en = 1'b0;
    logic rd_en = 1'b0;
    logic rd_d = 1'b0;
    logic deep_sleep_enable_f = 1'b0;
    logic bor_f = 1'b1;
    logic [3:0] evt = 4'h0;
    logic in_sleep, in_deep_sleep, pins_held, disable_locked;
    logic [15:0] pdir = 16'h0;
    logic [15:0] plat = 16'h0;
    logic [15:0] dir_o, lat_o, hdir, hlat;
    logic [127:0] md;
    logic [31:0] exp_q[$];
    int mismatches = 0;
    int checked = 0;
    int cycles = 0;
    int seed = 78;
    dsl_top #(.NPMD(4), .NPIN(16)) u_dut (
        .clk(clk), .rst(rst), .addr(addr), .wdata(wdata), .wr_en(wr_en),
        .rd_en(rd_en), .rdata(rdata), .config_word3(cw3),
        .deep_sleep_enable_fuse(deep_sleep_enable_f), .brownout_enable_fuse(bor_f),
        .wait_exec(evt[3]), .wake_ext(evt[2]), .wake_other(evt[1]),
        .supply_low(evt[0]), .in_sleep(in_sleep),
        .in_deep_sleep(in_deep_sleep), .pins_held(pins_held),
        .pin_direction(pdir), .pin_output_latch(plat),
        .pin_dir_out(dir_o), .pin_lat_out(lat_o),
        .module_disable(md), .disable_locked(disable_locked)
    );
    // 10 MHz clock
    always #50 clk = ~clk;
    task automatic summarize();
        $display("checked %0d mismatches %0d", checked, mismatches);
        if (mismatches == 0 && checked > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    task automatic check(input logic [31:0] seen, input logic [31:0] exp,
                         input string what);
        checked++;
        if (seen !== exp) begin
            mismatches++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask
    // Hang guard: the whole sequence needs well under a thousand cycles
    always @(posedge clk) begin
        cycles++;
        if (cycles == 3000) begin
            mismatches++;
            summarize();
        end
    end
    // Read data stand only in the cycle after the strobe
    always @(posedge clk) rd_d <= rd_en;
    always @(negedge clk) begin
        if (rd_d) begin
            check(rdata, exp_q.pop_front(), "rdata");
        end
    end
    // One bus cycle; on a read d is the expected data
    task automatic bus(input logic wr, input logic [7:0] a,
                       input logic [31:0] d);
        @(posedge clk);
        wr_en <= wr;
        rd_en <= !wr;
        addr <= a;
        wdata <= d;
        if (!wr) exp_q.push_back(d);
        @(posedge clk);
        wr_en <= 1'b0;
        rd_en <= 1'b0;
    endtask
    // Pulse power events, then look once the state has landed
    task automatic ev(input logic [3:0] e, input logic [2:0] s);
        @(posedge clk);
        evt <= e;
        @(posedge clk);
        evt <= 4'h0;
        @(negedge clk);
        check({29'h0, in_sleep, in_deep_sleep, pins_held}, {29'h0, s}, "st");
    endtask
    task automatic lock(input logic v);
        bus(1'b1, KEY_OFS, UNLOCK_KEY1);
        bus(1'b1, KEY_OFS, UNLOCK_KEY2);
        bus(1'b1, CFGCTL_OFS, {31'h0, v} << LOCK_BIT);
        @(negedge clk);
    endtask
    // Straps only change while reset is held
    task automatic do_reset(input logic [31:0] c, input logic f);
        @(posedge clk);
        rst <= 1'b1;
        cw3 <= c;
        deep_sleep_enable_f <= f;
        bor_f <= !f;
        pdir <= 16'($random(seed));
        plat <= 16'($random(seed));
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        repeat (2) @(posedge clk);
    endtask
    initial begin
        val = $random(seed);
        do_reset(val & ~(32'h1 << ONE_WAY_BIT), 1'b0);
        bus(1'b0, DSCTL_OFS, 32'h0);
        bus(1'b1, DSCTL_OFS, 32'hffff_7ffe);
        bus(1'b0, DSCTL_OFS, 32'h4);
        bus(1'b1, 8'h10, val);
        bus(1'b0, 8'h10, val);
        bus(1'b1, CFGCTL_OFS, 32'h1 << LOCK_BIT);
        @(negedge clk);
        check({31'h0, disable_locked}, 32'h0, "lock");
        lock(1'b1);
        check({31'h0, disable_locked}, 32'h1, "lock");
        bus(1'b1, 8'h10, ~val);
        bus(1'b0, 8'h10, val);
        lock(1'b0);
        check({31'h0, disable_locked}, 32'h0, "lock");
        // A stray key write between the two keys must spoil the unlock
        bus(1'b1, KEY_OFS, UNLOCK_KEY1);
        bus(1'b1, KEY_OFS, 32'h0000_0000);
        bus(1'b1, KEY_OFS, UNLOCK_KEY2);
        bus(1'b1, CFGCTL_OFS, 32'h1 << LOCK_BIT);
        @(negedge clk);
        check({31'h0, disable_locked}, 32'h0, "lock");
        ev(4'h8, 3'b100);
        ev(4'h2, 3'b000);
        bus(1'b1, DSCTL_OFS, 32'h8005);
        ev(4'h8, 3'b011);
        hdir = dir_o;
        hlat = lat_o;
        @(posedge clk);
        pdir <= ~pdir;
        plat <= ~plat;
        ev(4'h4, 3'b011);
        ev(4'h1, 3'b011);
        ev(4'h2, 3'b001);
        check({dir_o, lat_o}, {hdir, hlat}, "pins");
        bus(1'b0, DSCTL_OFS, 32'h7);
        bus(1'b1, DSCTL_OFS, 32'h0);
        repeat (2) @(negedge clk);
        check({dir_o, lat_o}, {pdir, plat}, "pins");
        bus(1'b1, DSCTL_OFS, 32'h8000);
        ev(4'h8, 3'b011);
        ev(4'h4, 3'b000);
        do_reset(val | (32'h1 << ONE_WAY_BIT), 1'b1);
        bus(1'b0, DSCTL_OFS, 32'h8000);
        ev(4'h8, 3'b011);
        ev(4'h1, 3'b011);
        ev(4'h2, 3'b000);
        bus(1'b0, DSCTL_OFS, 32'h0);
        lock(1'b1);
        lock(1'b0);
        check({31'h0, disable_locked}, 32'h1, "lock");
        bus(1'b1, 8'h10, val);
        bus(1'b0, 8'h10, 32'h0);
        do_reset(val | (32'h1 << ONE_WAY_BIT), 1'b1);
        check({31'h0, disable_locked}, 32'h0, "lock");
        bus(1'b1, 8'h10, val);
        bus(1'b0, 8'h10, val);
        repeat (2) @(posedge clk);
        summarize();
    end
endmodule
`default_nettype wire
